// ---- hdl/instr_timing_ctrl.sv ----
// Instruction sequencing, cycle-count control and execution datapath of the core
// Contract
// (RQ1) One instruction cycle is four system clocks; execution advances only at boundaries.
// (RQ2) Instructions complete in one instruction cycle unless another rule adds one.
// (RQ3) Jump, call, subroutine exit, interrupt exit and table read take two cycles.
// (RQ4) Writing the program counter low byte jumps there and adds one cycle.
// (RQ5) Skip takes one cycle without skipping, one more when skipping.
// (RQ6) Skip tests a memory byte or bit, then runs or bypasses next instruction.
// (RQ7) Addition beyond 255 sets carry; subtraction below zero sets borrow, 8-bit operands.
// (RQ8) Increment and decrement change value by one, result to memory or accumulator.
// (RQ9) AND, OR, XOR and complement set zero flag on zero result.
// (RQ10) Logical operations with memory route their data through the accumulator; complement here takes memory data directly, without it.
// (RQ11) Rotates shift one bit; through-carry variants move shifted-out bit to carry.
// (RQ12) Subroutine exit resumes right after the invoking instruction.
// (RQ13) Unconditional jump loads target without saving a return address.
// (RQ14) Bit set and clear alter only the selected bit of a byte.
// (RQ15) Table read fetches program memory data for the data side.
// (RQ16) Power-down instruction halts execution; watchdog control instructions exist.
// (RQ17) Interrupt exit sets global interrupt enable; subroutine exit leaves it.
// (RQ18) Two-cycle instructions discard the prefetch and refetch from the new counter.
module instr_timing_ctrl #(
  parameter int unsigned PC_W = instr_timing_pkg::PC_W,
  parameter int unsigned STACK_DEPTH = instr_timing_pkg::STACK_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire instr_timing_pkg::op_type i_op,
  input wire logic i_op_valid,
  input wire logic [7:0] i_mem_data,
  input wire logic [7:0] i_imm,
  input wire logic i_use_imm,
  input wire logic i_dest_acc,
  input wire logic i_dest_pc_low,
  input wire logic [2:0] i_bit_sel,
  input wire logic [PC_W-1:0] i_target,
  input wire logic [7:0] i_table_data,
  input wire logic i_wake,
  output logic [1:0] o_phase,
  output logic o_icycle_end,
  output logic [PC_W-1:0] o_pc,
  output logic o_fetch_flush,
  output logic o_busy_extra,
  output logic [7:0] o_acc,
  output logic o_carry,
  output logic o_zero,
  output logic o_mem_we,
  output logic [7:0] o_mem_wdata,
  output logic o_table_rd,
  output logic [7:0] o_table_latch,
  output logic o_global_irq_enable,
  output logic o_halted,
  output logic o_wdt_clear
);
  // ****************************************************************
  // Phase counter
  // ****************************************************************
  logic [1:0] phase_ff, nxt_phase;
  logic boundary;

  always_comb begin
    nxt_phase = phase_ff + 2'h1; // see (RQ1)
    boundary = (phase_ff == instr_timing_pkg::PHASE_LAST); // see (RQ1)
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      phase_ff <= instr_timing_pkg::PHASE_FIRST;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // ****************************************************************
  // Sequencer and datapath
  // ****************************************************************
  instr_timing_pkg::state_type state_ff, nxt_state;
  logic [PC_W-1:0] pc_ff, nxt_pc;
  logic [PC_W-1:0] stack_ff [STACK_DEPTH];
  logic [PC_W-1:0] nxt_stack [STACK_DEPTH];
  logic [$clog2(STACK_DEPTH):0] sp_ff, nxt_sp;
  logic [7:0] acc_ff, nxt_acc, wdata_ff, nxt_wdata, tbl_ff, nxt_tbl;
  logic carry_ff, nxt_carry, zero_ff, nxt_zero, gie_ff, nxt_gie;
  logic we_ff, nxt_we, flush_ff, nxt_flush, trd_ff, nxt_trd, wdt_ff, nxt_wdt, end_ff;
  logic [8:0] sum;
  logic [7:0] opnd, res, mask;
  logic two_cycle, write_res, skip, skip_op;
  logic busy_ff, nxt_busy, halted_ff, nxt_halted;
  localparam int unsigned SP_W = $clog2(STACK_DEPTH) + 1;

  always_comb begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_stack = stack_ff;
    nxt_sp = sp_ff;
    nxt_acc = acc_ff;
    nxt_wdata = wdata_ff;
    nxt_tbl = tbl_ff;
    nxt_carry = carry_ff;
    nxt_zero = zero_ff;
    nxt_gie = gie_ff;
    nxt_we = 1'b0;
    nxt_flush = 1'b0;
    nxt_trd = 1'b0;
    nxt_wdt = 1'b0;
    sum = 9'h000;
    res = acc_ff;
    opnd = i_use_imm ? i_imm : i_mem_data;
    mask = instr_timing_pkg::BYTE_ONE << i_bit_sel;
    two_cycle = 1'b0;
    write_res = 1'b0;
    skip = 1'b0;
    skip_op = 1'b0;
    case (state_ff)
      instr_timing_pkg::st_run: begin
        if (boundary && i_op_valid) begin // see (RQ1)
          nxt_pc = pc_ff + instr_timing_pkg::PC_STEP;
          case (i_op)
            instr_timing_pkg::op_add, instr_timing_pkg::op_adc: begin
              sum = {1'b0, acc_ff} + {1'b0, opnd} + {8'h00, (i_op == instr_timing_pkg::op_adc) & carry_ff};
              res = sum[7:0];
              nxt_carry = sum[8]; // see (RQ7)
              nxt_zero = (res == instr_timing_pkg::BYTE_ZERO);
              write_res = 1'b1;
            end
            instr_timing_pkg::op_sub, instr_timing_pkg::op_sbc: begin
              sum = {1'b0, acc_ff} - {1'b0, opnd} - {8'h00, (i_op == instr_timing_pkg::op_sbc) & ~carry_ff};
              res = sum[7:0];
              nxt_carry = ~sum[8]; // see (RQ7)
              nxt_zero = (res == instr_timing_pkg::BYTE_ZERO);
              write_res = 1'b1;
            end
            instr_timing_pkg::op_and, instr_timing_pkg::op_or, instr_timing_pkg::op_xor: begin
              // Operand always meets the accumulator first
              res = (i_op == instr_timing_pkg::op_and) ? (acc_ff & opnd) :
                    (i_op == instr_timing_pkg::op_or) ? (acc_ff | opnd) : (acc_ff ^ opnd); // see (RQ10)
              nxt_zero = (res == instr_timing_pkg::BYTE_ZERO); // see (RQ9)
              write_res = 1'b1;
            end
            instr_timing_pkg::op_complement_mem: begin
              res = ~i_mem_data;
              nxt_zero = (res == instr_timing_pkg::BYTE_ZERO); // see (RQ9)
              write_res = 1'b1;
            end
            instr_timing_pkg::op_add_one, instr_timing_pkg::op_sub_one_mem: begin
              res = (i_op == instr_timing_pkg::op_add_one) ? i_mem_data + instr_timing_pkg::BYTE_ONE :
                    i_mem_data - instr_timing_pkg::BYTE_ONE; // see (RQ8)
              nxt_zero = (res == instr_timing_pkg::BYTE_ZERO);
              write_res = 1'b1;
            end
            instr_timing_pkg::op_rotate_right_plain: begin
              res = {i_mem_data[0], i_mem_data[7:1]}; // see (RQ11)
              write_res = 1'b1;
            end
            instr_timing_pkg::op_rotate_left_plain: begin
              res = {i_mem_data[6:0], i_mem_data[7]}; // see (RQ11)
              write_res = 1'b1;
            end
            instr_timing_pkg::op_rotate_right_via_carry: begin
              res = {carry_ff, i_mem_data[7:1]};
              nxt_carry = i_mem_data[0]; // see (RQ11)
              write_res = 1'b1;
            end
            instr_timing_pkg::op_rotate_left_via_carry: begin
              res = {i_mem_data[6:0], carry_ff};
              nxt_carry = i_mem_data[7]; // see (RQ11)
              write_res = 1'b1;
            end
            instr_timing_pkg::op_bit_force_high, instr_timing_pkg::op_bit_force_low: begin
              // Read-modify-write keeps the other seven bits
              res = (i_op == instr_timing_pkg::op_bit_force_high) ? (i_mem_data | mask) :
                    (i_mem_data & ~mask); // see (RQ14)
              write_res = 1'b1;
            end
            instr_timing_pkg::op_mov: begin
              res = i_dest_acc ? opnd : acc_ff;
              write_res = 1'b1;
            end
            instr_timing_pkg::op_jump_unconditional: begin
              nxt_pc = i_target; // see (RQ13)
              two_cycle = 1'b1; // see (RQ3)
            end
            instr_timing_pkg::op_call: begin
              if (sp_ff < STACK_DEPTH[$clog2(STACK_DEPTH):0]) begin
                nxt_stack[sp_ff[$clog2(STACK_DEPTH)-1:0]] = pc_ff + instr_timing_pkg::PC_STEP; // see (RQ12)
                nxt_sp = sp_ff + SP_W'(1);
              end
              nxt_pc = i_target;
              two_cycle = 1'b1; // see (RQ3)
            end
            instr_timing_pkg::op_subroutine_exit, instr_timing_pkg::op_interrupt_exit: begin
              if (sp_ff != '0) begin
                nxt_sp = sp_ff - SP_W'(1);
                nxt_pc = stack_ff[nxt_sp[$clog2(STACK_DEPTH)-1:0]]; // see (RQ12)
              end
              if (i_op == instr_timing_pkg::op_interrupt_exit) begin
                nxt_gie = 1'b1; // see (RQ17)
              end
              two_cycle = 1'b1; // see (RQ3)
            end
            instr_timing_pkg::op_table_read: begin
              nxt_tbl = i_table_data; // see (RQ15)
              nxt_trd = 1'b1;
              two_cycle = 1'b1; // see (RQ3)
            end
            instr_timing_pkg::op_skip_zero, instr_timing_pkg::op_skip_nonzero,
            instr_timing_pkg::op_skip_bit_zero, instr_timing_pkg::op_skip_bit_one: begin
              skip_op = 1'b1;
              case (i_op)
                instr_timing_pkg::op_skip_zero: skip = (i_mem_data == instr_timing_pkg::BYTE_ZERO); // see (RQ6)
                instr_timing_pkg::op_skip_nonzero: skip = (i_mem_data != instr_timing_pkg::BYTE_ZERO);
                instr_timing_pkg::op_skip_bit_zero: skip = ~i_mem_data[i_bit_sel];
                default: skip = i_mem_data[i_bit_sel];
              endcase
              if (i_dest_acc) begin
                nxt_acc = i_mem_data;
              end
              if (skip) begin
                nxt_pc = pc_ff + instr_timing_pkg::PC_STEP + instr_timing_pkg::PC_STEP; // see (RQ6)
                two_cycle = 1'b1; // see (RQ5)
              end
            end
            instr_timing_pkg::op_halt: begin
              nxt_state = instr_timing_pkg::st_halted; // see (RQ16)
            end
            instr_timing_pkg::op_wdt_clear: begin
              nxt_wdt = 1'b1; // see (RQ16)
            end
            default: begin
            end
          endcase
          if (write_res && !skip_op) begin
            if (i_dest_acc) begin
              nxt_acc = res; // see (RQ8)
            end else if (i_dest_pc_low) begin
              nxt_pc = {pc_ff[PC_W-1:8], res}; // see (RQ4)
              two_cycle = 1'b1; // see (RQ4)
            end else begin
              nxt_we = 1'b1;
              nxt_wdata = res;
            end
          end
          if (two_cycle) begin
            // Prefetched word is stale once the counter jumps
            nxt_flush = 1'b1; // see (RQ18)
            nxt_state = instr_timing_pkg::st_extra;
          end
        end
      end
      instr_timing_pkg::st_extra: begin
        if (boundary) begin
          nxt_state = instr_timing_pkg::st_run; // see (RQ2)
        end
      end
      instr_timing_pkg::st_halted: begin
        // Wake only lines up on a boundary so phases stay aligned
        if (boundary && i_wake) begin
          nxt_state = instr_timing_pkg::st_run; // see (RQ16)
        end
      end
      default: begin
        nxt_state = instr_timing_pkg::st_run;
      end
    endcase
    // Registered decodes keep these outputs glitch free
    nxt_busy = (nxt_state == instr_timing_pkg::st_extra);
    nxt_halted = (nxt_state == instr_timing_pkg::st_halted);
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_ff <= instr_timing_pkg::st_run;
      pc_ff <= instr_timing_pkg::PC_RESET[PC_W-1:0];
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_ff[i] <= '0;
      end
      sp_ff <= '0;
      acc_ff <= instr_timing_pkg::BYTE_ZERO;
      wdata_ff <= instr_timing_pkg::BYTE_ZERO;
      tbl_ff <= instr_timing_pkg::BYTE_ZERO;
      carry_ff <= 1'b0;
      zero_ff <= 1'b0;
      gie_ff <= 1'b0;
      we_ff <= 1'b0;
      flush_ff <= 1'b0;
      trd_ff <= 1'b0;
      wdt_ff <= 1'b0;
      end_ff <= 1'b0;
      busy_ff <= 1'b0;
      halted_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      stack_ff <= nxt_stack;
      sp_ff <= nxt_sp;
      acc_ff <= nxt_acc;
      wdata_ff <= nxt_wdata;
      tbl_ff <= nxt_tbl;
      carry_ff <= nxt_carry;
      zero_ff <= nxt_zero;
      gie_ff <= nxt_gie;
      we_ff <= nxt_we;
      flush_ff <= nxt_flush;
      trd_ff <= nxt_trd;
      wdt_ff <= nxt_wdt;
      end_ff <= boundary;
      busy_ff <= nxt_busy;
      halted_ff <= nxt_halted;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    o_phase = phase_ff;
    o_icycle_end = end_ff;
    o_pc = pc_ff;
    o_fetch_flush = flush_ff;
    o_busy_extra = busy_ff;
    o_acc = acc_ff;
    o_carry = carry_ff;
    o_zero = zero_ff;
    o_mem_we = we_ff;
    o_mem_wdata = wdata_ff;
    o_table_rd = trd_ff;
    o_table_latch = tbl_ff;
    o_global_irq_enable = gie_ff;
    o_halted = halted_ff;
    o_wdt_clear = wdt_ff;
  end
endmodule

// ---- hdl/instr_timing_pkg.sv ----
// Package with constants and types for the instruction timing control block
package instr_timing_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLKS_PER_ICYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_FIRST = 2'h0;

  // ****************************************************************
  // Widths and values
  // ****************************************************************
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W = 13;
  localparam int unsigned STACK_DEPTH = 8;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] PC_STEP = 13'h0001;

  // ****************************************************************
  // Decoded operation classes
  // ****************************************************************
  typedef enum logic [4:0] {
    op_nop, op_add, op_adc, op_sub, op_sbc, op_and, op_or, op_xor,
    op_complement_mem, op_add_one, op_sub_one_mem,
    op_rotate_right_plain, op_rotate_left_plain, op_rotate_right_via_carry, op_rotate_left_via_carry,
    op_bit_force_high, op_bit_force_low, op_mov,
    op_jump_unconditional, op_call, op_subroutine_exit, op_interrupt_exit,
    op_table_read, op_skip_zero, op_skip_nonzero, op_skip_bit_zero, op_skip_bit_one,
    op_halt, op_wdt_clear
  } op_type;

  typedef enum {
    st_run,
    st_extra,
    st_halted
  } state_type;
endpackage

// ---- sim/instr_timing_ctrl_props.sv ----
// Concurrent checks on the ports of the instruction timing control block
module instr_timing_ctrl_props #(
  parameter int unsigned PC_W = instr_timing_pkg::PC_W
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire instr_timing_pkg::op_type i_op,
  input wire logic i_op_valid,
  input wire logic [7:0] i_mem_data,
  input wire logic [7:0] i_imm,
  input wire logic i_use_imm,
  input wire logic i_dest_acc,
  input wire logic i_dest_pc_low,
  input wire logic [2:0] i_bit_sel,
  input wire logic [PC_W-1:0] i_target,
  input wire logic [1:0] o_phase,
  input wire logic o_icycle_end,
  input wire logic [PC_W-1:0] o_pc,
  input wire logic o_fetch_flush,
  input wire logic o_busy_extra,
  input wire logic [7:0] o_acc,
  input wire logic o_carry,
  input wire logic [7:0] o_mem_wdata,
  input wire logic o_global_irq_enable,
  input wire logic o_halted
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Helpers
  // ****************************************************************
  logic take;
  logic [8:0] sum_w;
  assign take = o_phase == 2'h3 && !o_busy_extra && !o_halted && i_op_valid;
  assign sum_w = {1'b0, o_acc} + {1'b0, i_use_imm ? i_imm : i_mem_data};
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  // First edge after reset still sees the reset phase, hence the guard
  a_phase_steps: assert property ($past(i_resetn) |-> o_phase == $past(o_phase) + 2'h1)
    else $error("phase did not step");
  a_boundary_mark: assert property ($past(i_resetn) |-> o_icycle_end == (o_phase == 2'h0))
    else $error("cycle end mark wrong");
  a_plain_single: assert property (take && i_op == instr_timing_pkg::op_add && !i_dest_pc_low
    |=> !o_busy_extra && !o_fetch_flush)
    else $error("plain op took extra cycle");
  a_extra_four_clocks: assert property ($rose(o_busy_extra) |-> o_busy_extra [*4] ##1 !o_busy_extra)
    else $error("extra cycle length wrong");
  a_branch_refetch: assert property (take && i_op inside {instr_timing_pkg::op_jump_unconditional,
    instr_timing_pkg::op_call, instr_timing_pkg::op_subroutine_exit, instr_timing_pkg::op_interrupt_exit,
    instr_timing_pkg::op_table_read} |=> o_busy_extra && o_fetch_flush)
    else $error("two cycle op not extended");
  a_jump_target: assert property (take && i_op == instr_timing_pkg::op_jump_unconditional
    |=> o_pc == $past(i_target))
    else $error("jump target not loaded");
  a_pc_low_extra: assert property (take && i_op == instr_timing_pkg::op_mov && i_dest_pc_low && !i_dest_acc
    |=> o_busy_extra && o_fetch_flush)
    else $error("pc low write not extended");
  a_skip_cost: assert property (take && i_op == instr_timing_pkg::op_skip_zero
    |=> o_busy_extra == ($past(i_mem_data) == 8'h00))
    else $error("skip cycle count wrong");
  a_add_carry: assert property (take && i_op == instr_timing_pkg::op_add |=> o_carry == $past(sum_w[8]))
    else $error("add carry wrong");
  a_bit_clear: assert property (take && i_op == instr_timing_pkg::op_bit_force_low && !i_dest_acc && !i_dest_pc_low
    |=> o_mem_wdata == ($past(i_mem_data) & ~(8'h01 << $past(i_bit_sel))))
    else $error("bit clear altered other bits");
  a_irq_on_exit: assert property (take && i_op == instr_timing_pkg::op_interrupt_exit
    |=> o_global_irq_enable)
    else $error("interrupt exit left enable low");
  a_halt_entry: assert property (take && i_op == instr_timing_pkg::op_halt |=> o_halted)
    else $error("halt not entered");
endmodule

bind instr_timing_ctrl instr_timing_ctrl_props #(.PC_W(PC_W)) props_inst (.i_clk, .i_resetn, .i_op, .i_op_valid,
  .i_mem_data, .i_imm, .i_use_imm, .i_dest_acc, .i_dest_pc_low, .i_bit_sel, .i_target, .o_phase, .o_icycle_end, .o_pc,
  .o_fetch_flush, .o_busy_extra, .o_acc, .o_carry, .o_mem_wdata, .o_global_irq_enable, .o_halted);

// ---- sim/instr_timing_ctrl_tb.sv ----
// Self-checking testbench for the instruction timing control block
module instr_timing_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_resetn, i_op_valid, i_use_imm, i_dest_acc, i_dest_pc_low, i_wake;
  instr_timing_pkg::op_type i_op;
  logic [7:0] i_mem_data, i_imm, i_table_data, o_acc, o_mem_wdata, o_table_latch, wd_s;
  logic [2:0] i_bit_sel;
  logic [12:0] i_target, o_pc, pc0;
  logic [1:0] o_phase;
  logic o_icycle_end, o_fetch_flush, o_busy_extra, o_carry, o_zero, o_mem_we, o_table_rd;
  logic o_global_irq_enable, o_halted, o_wdt_clear, we_s, fl_s, tr_s, wc_s;
  int n_errors, n_tests, cyc;

  instr_timing_ctrl instr_timing_ctrl_inst (.i_clk, .i_resetn, .i_op, .i_op_valid, .i_mem_data, .i_imm,
    .i_use_imm, .i_dest_acc, .i_dest_pc_low, .i_bit_sel, .i_target, .i_table_data, .i_wake, .o_phase,
    .o_icycle_end, .o_pc, .o_fetch_flush, .o_busy_extra, .o_acc, .o_carry, .o_zero, .o_mem_we, .o_mem_wdata,
    .o_table_rd, .o_table_latch, .o_global_irq_enable, .o_halted, .o_wdt_clear);

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
      n_errors++;
    end
  endtask

  // Issues one op at a boundary, snapshots the pulses, counts clocks to the next free boundary
  task automatic op_go(input instr_timing_pkg::op_type op, input logic [7:0] mem, input logic [7:0] imm,
    input logic [2:0] fl, input logic [2:0] bs, input logic [15:0] clks);
    int n;
    while (!(o_phase === 2'h3 && o_busy_extra === 1'b0 && o_halted === 1'b0)) @(negedge i_clk);
    pc0 = o_pc;
    i_op = op;
    i_mem_data = mem;
    i_imm = imm;
    i_bit_sel = bs;
    {i_use_imm, i_dest_acc, i_dest_pc_low} = fl;
    i_op_valid = 1'b1;
    @(negedge i_clk);
    i_op_valid = 1'b0;
    {we_s, wd_s, fl_s, tr_s, wc_s} = {o_mem_we, o_mem_wdata, o_fetch_flush, o_table_rd, o_wdt_clear};
    n = 1;
    while (!(o_phase === 2'h3 && o_busy_extra === 1'b0) && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    if (clks != 16'h0) chk("clocks", clks, 16'(n));
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_timing();
    int e;
    e = 0;
    repeat (8) begin
      @(negedge i_clk);
      if (o_icycle_end === 1'b1) e++;
    end
    chk("icycle_end", 16'h0002, 16'(e));
    $display("test timing done");
  endtask

  task automatic t_branch();
    logic [12:0] p;
    i_target = 13'h0123;
    op_go(instr_timing_pkg::op_call, 8'h00, 8'h00, 3'h0, 3'h0, 16'h0008);
    p = pc0;
    chk("call pc", 16'h0123, {3'h0, o_pc});
    chk("flush", 16'h0001, {15'h0, fl_s});
    i_target = 13'h1ABC;
    op_go(instr_timing_pkg::op_jump_unconditional, 8'h00, 8'h00, 3'h0, 3'h0, 16'h0008);
    chk("jump pc", 16'h1ABC, {3'h0, o_pc});
    op_go(instr_timing_pkg::op_subroutine_exit, 8'h00, 8'h00, 3'h0, 3'h0, 16'h0008);
    chk("exit pc", {3'h0, p + 13'h0001}, {3'h0, o_pc});
    chk("irq en", 16'h0000, {15'h0, o_global_irq_enable});
    op_go(instr_timing_pkg::op_interrupt_exit, 8'h00, 8'h00, 3'h0, 3'h0, 16'h0008);
    chk("irq en", 16'h0001, {15'h0, o_global_irq_enable});
    $display("test branch done");
  endtask

  task automatic t_alu();
    op_go(instr_timing_pkg::op_mov, 8'h00, 8'hF0, 3'h6, 3'h0, 16'h0004);
    op_go(instr_timing_pkg::op_add, 8'h00, 8'h20, 3'h6, 3'h0, 16'h0004);
    chk("add", 16'h0110, {7'h0, o_carry, o_acc});
    op_go(instr_timing_pkg::op_sub, 8'h00, 8'h20, 3'h6, 3'h0, 16'h0004);
    chk("sub", 16'h00F0, {7'h0, o_carry, o_acc});
    op_go(instr_timing_pkg::op_and, 8'h00, 8'h0F, 3'h6, 3'h0, 16'h0004);
    chk("and", 16'h0100, {7'h0, o_zero, o_acc});
    op_go(instr_timing_pkg::op_or, 8'h00, 8'h81, 3'h6, 3'h0, 16'h0004);
    chk("or", 16'h0081, {7'h0, o_zero, o_acc});
    op_go(instr_timing_pkg::op_xor, 8'h00, 8'h81, 3'h6, 3'h0, 16'h0004);
    chk("xor", 16'h0100, {7'h0, o_zero, o_acc});
    op_go(instr_timing_pkg::op_complement_mem, 8'h0F, 8'h00, 3'h0, 3'h0, 16'h0004);
    chk("cpl", 16'h01F0, {6'h0, o_zero, we_s, wd_s});
    op_go(instr_timing_pkg::op_add_one, 8'hFF, 8'h00, 3'h2, 3'h0, 16'h0004);
    chk("inc", 16'h0000, {8'h0, o_acc});
    op_go(instr_timing_pkg::op_sub_one_mem, 8'h00, 8'h00, 3'h0, 3'h0, 16'h0004);
    chk("dec", 16'h01FF, {7'h0, we_s, wd_s});
    $display("test alu done");
  endtask

  task automatic t_rot_bits();
    op_go(instr_timing_pkg::op_rotate_left_via_carry, 8'h80, 8'h00, 3'h2, 3'h0, 16'h0004);
    chk("rlc carry", 16'h0001, {15'h0, o_carry});
    op_go(instr_timing_pkg::op_rotate_left_via_carry, 8'h00, 8'h00, 3'h2, 3'h0, 16'h0004);
    chk("rlc", 16'h0001, {7'h0, o_carry, o_acc});
    op_go(instr_timing_pkg::op_sbc, 8'h00, 8'h00, 3'h6, 3'h0, 16'h0004);
    chk("sbc", 16'h0100, {7'h0, o_carry, o_acc});
    op_go(instr_timing_pkg::op_adc, 8'h00, 8'h10, 3'h6, 3'h0, 16'h0004);
    chk("adc", 16'h0011, {7'h0, o_carry, o_acc});
    op_go(instr_timing_pkg::op_rotate_right_via_carry, 8'h01, 8'h00, 3'h2, 3'h0, 16'h0004);
    chk("rrc", 16'h0100, {7'h0, o_carry, o_acc});
    op_go(instr_timing_pkg::op_rotate_left_plain, 8'h81, 8'h00, 3'h0, 3'h0, 16'h0004);
    chk("rl", 16'h0103, {7'h0, we_s, wd_s});
    op_go(instr_timing_pkg::op_bit_force_high, 8'h00, 8'h00, 3'h0, 3'h3, 16'h0004);
    chk("bit high", 16'h0108, {7'h0, we_s, wd_s});
    op_go(instr_timing_pkg::op_rotate_right_plain, 8'h01, 8'h00, 3'h0, 3'h0, 16'h0004);
    chk("rr", 16'h0180, {7'h0, we_s, wd_s});
    op_go(instr_timing_pkg::op_bit_force_low, 8'hFF, 8'h00, 3'h0, 3'h7, 16'h0004);
    chk("bit low", 16'h017F, {7'h0, we_s, wd_s});
    $display("test rotate bits done");
  endtask

  task automatic t_skip_pcl();
    op_go(instr_timing_pkg::op_skip_zero, 8'h00, 8'h00, 3'h0, 3'h0, 16'h0008);
    chk("skip pc", {3'h0, pc0 + 13'h0002}, {3'h0, o_pc});
    op_go(instr_timing_pkg::op_skip_nonzero, 8'h00, 8'h00, 3'h0, 3'h0, 16'h0004);
    chk("no skip pc", {3'h0, pc0 + 13'h0001}, {3'h0, o_pc});
    op_go(instr_timing_pkg::op_skip_bit_one, 8'h04, 8'h00, 3'h0, 3'h2, 16'h0008);
    op_go(instr_timing_pkg::op_skip_bit_zero, 8'hFB, 8'h00, 3'h2, 3'h2, 16'h0008);
    chk("skip acc", 16'h00FB, {8'h0, o_acc});
    op_go(instr_timing_pkg::op_mov, 8'h00, 8'h40, 3'h6, 3'h0, 16'h0004);
    op_go(instr_timing_pkg::op_mov, 8'h00, 8'h00, 3'h1, 3'h0, 16'h0008);
    chk("pcl", 16'h0140, {7'h0, fl_s, o_pc[7:0]});
    $display("test skip pcl done");
  endtask

  task automatic t_table_halt();
    int n;
    i_table_data = 8'h5A;
    op_go(instr_timing_pkg::op_table_read, 8'h00, 8'h00, 3'h0, 3'h0, 16'h0008);
    chk("table", 16'h015A, {7'h0, tr_s, o_table_latch});
    op_go(instr_timing_pkg::op_wdt_clear, 8'h00, 8'h00, 3'h0, 3'h0, 16'h0004);
    chk("wdt", 16'h0001, {15'h0, wc_s});
    op_go(instr_timing_pkg::op_halt, 8'h00, 8'h00, 3'h0, 3'h0, 16'h0000);
    // Valid stays high while halted: it must be ignored
    i_op = instr_timing_pkg::op_jump_unconditional;
    i_op_valid = 1'b1;
    repeat (8) @(negedge i_clk);
    chk("halt", {2'h0, 1'b1, pc0 + 13'h0001}, {2'h0, o_halted, o_pc});
    i_op_valid = 1'b0;
    i_wake = 1'b1;
    n = 0;
    while (o_halted !== 1'b0 && n < 12) begin
      @(negedge i_clk);
      n++;
    end
    i_wake = 1'b0;
    chk("woken", 16'h0000, {15'h0, o_halted});
    $display("test table halt done");
  endtask

  // ****************************************************************
  // Clock, timeout and main sequence
  // ****************************************************************
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    {i_resetn, i_op_valid, i_use_imm, i_dest_acc, i_dest_pc_low, i_wake} = 6'h00;
    i_op = instr_timing_pkg::op_nop;
    {i_mem_data, i_imm, i_table_data, i_bit_sel, i_target} = 40'h0;
    repeat (3) @(negedge i_clk);
    i_resetn = 1'b1;
    t_timing();
    t_branch();
    t_alu();
    t_rot_bits();
    t_skip_pcl();
    t_table_halt();
    wrap_up();
  end
endmodule
